/* File: nqu_pkg.sv */
// Package: register map, field layout and constants of the upconverter
package nqu_pkg;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_MODE       = 8'h01;
  localparam logic [7:0]  ADDR_STEP       = 8'h0a;
  localparam logic [7:0]  ADDR_PHASE      = 8'h0b;
  localparam logic [7:0]  ADDR_GAIN       = 8'h0c;
  localparam logic [7:0]  ADDR_OFFSET     = 8'h0d;
  localparam int          BIT_AUTO_XFER   = 1;
  localparam int          BIT_MAN_UPDATE  = 2;
  localparam int          BIT_SINC_EN     = 9;
  localparam int          BIT_SPEC_INV    = 10;
  localparam int          PH_SHIFT_LSB    = 0;
  localparam int          PH_SKEW_LSB     = 16;
  localparam int          GAIN_I_LSB      = 0;
  localparam int          GAIN_Q_LSB      = 16;
  localparam int          OFS_I_LSB       = 16;
  localparam int          OFS_Q_LSB       = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0002;
  localparam logic [31:0] MODE_RESET      = 32'h0000_0000;
  localparam logic [31:0] STEP_RESET      = 32'h0000_0000;
  localparam logic [31:0] PHASE_RESET     = 32'h0000_0000;
  localparam logic [31:0] GAIN_RESET      = 32'h0080_0080;
  localparam logic [31:0] OFFSET_RESET    = 32'h0000_0000;
  localparam logic [8:0]  GAIN_UNITY      = 9'h080;
  localparam int          GAIN_SHIFT      = 7;
  localparam int          SINC_SHIFT      = 9;
  localparam int          SINC_TAPS       = 9;
  localparam int          LUT_BITS        = 8;
  localparam logic signed [15:0] SAMP_MAX = 16'sh7fff;
  localparam logic signed [15:0] SAMP_MIN = -16'sh7fff - 16'sh0001;
endpackage

/* File: nqu_upconverter.sv */
// Carrier oscillator, quadrature modulator and output correction chain
`timescale 1ns/100ps
module nqu_upconverter
  import nqu_pkg::*;
(
  input  wire logic        clk,         // Converter sample clock
  input  wire logic        reset,       // Asynchronous reset, active high
  input  wire logic        cfgWrite,    // Serial write completed strobe
  input  wire logic [7:0]  cfgAddr,     // Register address
  input  wire logic [31:0] cfgWdata,    // Register write data
  input  wire logic [7:0]  cfgRaddr,    // Readback address
  output logic      [31:0] cfgRdata,    // Readback data
  input  wire logic        pulseSync,   // Pulse synchronisation mode
  input  wire logic        txGateStrobe,// Accumulator reset strobe
  input  wire logic [15:0] dataI,       // Upsampled I sample
  input  wire logic [15:0] dataQ,       // Upsampled Q sample
  output logic      [15:0] sampleOut    // Sample to converter core
);

  logic [31:0] ctrl, next_ctrl, mode, next_mode;
  logic [31:0] shStep, shPhase, shGain, shOfs;
  logic [31:0] next_shStep, next_shPhase, next_shGain, next_shOfs;
  logic [31:0] acStep, acPhase, acGain, acOfs;
  logic [31:0] next_acStep, next_acPhase, next_acGain, next_acOfs;
  logic [31:0] next_cfgRdata;

  // Register file and double buffering
  always_comb begin
    next_ctrl    = ctrl;
    next_mode    = mode;
    next_shStep  = shStep;
    next_shPhase = shPhase;
    next_shGain  = shGain;
    next_shOfs   = shOfs;
    next_acStep  = acStep;
    next_acPhase = acPhase;
    next_acGain  = acGain;
    next_acOfs   = acOfs;
    next_ctrl[BIT_MAN_UPDATE] = 1'b0;
    if (cfgWrite) begin
      case (cfgAddr)
        ADDR_CTRL:   next_ctrl    = cfgWdata;
        ADDR_MODE:   next_mode    = cfgWdata;
        ADDR_STEP:   next_shStep  = cfgWdata;
        ADDR_PHASE:  next_shPhase = cfgWdata;
        ADDR_GAIN:   next_shGain  = cfgWdata;
        ADDR_OFFSET: next_shOfs   = cfgWdata;
        default: ;
      endcase
    end
    if (ctrl[BIT_AUTO_XFER]) begin
      next_acStep  = next_shStep;
      next_acPhase = next_shPhase;
      next_acGain  = next_shGain;
      next_acOfs   = next_shOfs;
    end
    // manual update copies all at once
    if (ctrl[BIT_MAN_UPDATE]) begin
      next_acStep  = shStep;
      next_acPhase = shPhase;
      next_acGain  = shGain;
      next_acOfs   = shOfs;
    end
    case (cfgRaddr)
      ADDR_CTRL:   next_cfgRdata = ctrl;
      ADDR_MODE:   next_cfgRdata = mode;
      ADDR_STEP:   next_cfgRdata = shStep;
      ADDR_PHASE:  next_cfgRdata = shPhase;
      ADDR_GAIN:   next_cfgRdata = shGain;
      ADDR_OFFSET: next_cfgRdata = shOfs;
      default:     next_cfgRdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl     <= CTRL_RESET;
      mode     <= MODE_RESET;
      shStep   <= STEP_RESET;
      shPhase  <= PHASE_RESET;
      shGain   <= GAIN_RESET;
      shOfs    <= OFFSET_RESET;
      acStep   <= STEP_RESET;
      acPhase  <= PHASE_RESET;
      acGain   <= GAIN_RESET;
      acOfs    <= OFFSET_RESET;
      cfgRdata <= 32'h0000_0000;
    end else begin
      ctrl     <= next_ctrl;
      mode     <= next_mode;
      shStep   <= next_shStep;
      shPhase  <= next_shPhase;
      shGain   <= next_shGain;
      shOfs    <= next_shOfs;
      acStep   <= next_acStep;
      acPhase  <= next_acPhase;
      acGain   <= next_acGain;
      acOfs    <= next_acOfs;
      cfgRdata <= next_cfgRdata;
    end
  end

  // Carrier oscillator
  logic [31:0] phaseAcc, next_phaseAcc;
  logic [15:0] cosPh, sinPh;
  logic signed [15:0] cosVal, sinVal;
  logic signed [9:0]  skew;

  // Quarter-wave free sine from a coarse table, keeps area small
  function automatic logic signed [15:0] sinLut(input logic [15:0] ph);
    logic [LUT_BITS-1:0] idx;
    logic signed [15:0] v;
    idx = ph[15:16-LUT_BITS];
    v = 16'($rtoi(32767.0 * $sin(6.283185307179586 * idx / 256.0)));
    return v;
  endfunction

  always_comb begin
    next_phaseAcc = phaseAcc + acStep;
    // strobe in pulse mode clears accumulator
    if (pulseSync && txGateStrobe) begin
      next_phaseAcc = 32'h0000_0000;
    end
    skew = acPhase[PH_SKEW_LSB +: 10];
    cosPh = phaseAcc[31:16] + acPhase[PH_SHIFT_LSB +: 16];
    // sine lags cosine by a quarter turn
    // skew moves Q carrier about 14 degrees at ends
    sinPh = cosPh - 16'h4000 + 16'({{6{skew[9]}}, skew} * 16'sd5);
    cosVal = sinLut(cosPh + 16'h4000);
    sinVal = sinLut(sinPh + 16'h4000);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phaseAcc <= 32'h0000_0000;
    end else begin
      phaseAcc <= next_phaseAcc;
    end
  end

  // Modulator, inverse sinc, gain and offset stages
  logic signed [15:0] modOut, next_modOut;
  logic signed [15:0] tapLine [SINC_TAPS];
  logic signed [15:0] next_tap [SINC_TAPS];
  logic signed [15:0] sincOut, next_sincOut;
  logic signed [15:0] gainPipe, next_gainPipe;
  logic signed [15:0] next_sampleOut;
  logic signed [31:0] prodI, prodQ;
  logic signed [33:0] sincAcc;
  logic signed [26:0] gainProd;
  logic signed [16:0] ofsSum;
  logic signed [15:0] sinSel, stagePath, gainSrc;
  logic [8:0]         gainI;

  localparam logic signed [9:0] SINC_COEF [SINC_TAPS] =
    '{10'sd2, -10'sd4, 10'sd10, -10'sd35, 10'sd401,
      -10'sd35, 10'sd10, -10'sd4, 10'sd2};

  // Saturate to sample range
  function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'(SAMP_MAX)) return SAMP_MAX;
    if (v < 34'(SAMP_MIN)) return SAMP_MIN;
    return v[15:0];
  endfunction

  always_comb begin
    // negated sine unless inversion bit set
    sinSel = mode[BIT_SPEC_INV] ? sinVal : -sinVal;
    // I times cosine plus Q times sine
    // one carrier sample per data sample
    prodI = $signed(dataI) * cosVal;
    prodQ = $signed(dataQ) * sinSel;
    // Sum in 34 bits: two full-scale products overflow 32 bits
    next_modOut = sat16((34'(prodI) + 34'(prodQ)) >>> 15);
    next_tap[0] = modOut;
    sincAcc = '0;
    for (int k = 1; k < SINC_TAPS; k++) begin
      next_tap[k] = tapLine[k-1];
    end
    for (int k = 0; k < SINC_TAPS; k++) begin
      sincAcc = sincAcc + 34'(tapLine[k]) * 34'(SINC_COEF[k]);
    end
    next_sincOut = sat16(sincAcc >>> SINC_SHIFT);
    // FIR only in path when enabled
    stagePath = mode[BIT_SINC_EN] ? sincOut : modOut;
    // Combined path carries I gain and offset
    gainI = acGain[GAIN_I_LSB +: 9];
    gainProd = stagePath * $signed({1'b0, gainI});
    next_gainPipe = sat16(34'(gainProd >>> GAIN_SHIFT));
    // unity gain skips the multiplier stage
    // host matches gains to keep latency equal
    gainSrc = (gainI == GAIN_UNITY) ? stagePath : gainPipe;
    ofsSum = 17'(gainSrc) + 17'($signed(acOfs[OFS_I_LSB +: 16]));
    next_sampleOut = sat16(34'(ofsSum));
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modOut    <= 16'sh0000;
      sincOut   <= 16'sh0000;
      gainPipe  <= 16'sh0000;
      sampleOut <= 16'h0000;
      for (int k = 0; k < SINC_TAPS; k++) begin
        tapLine[k] <= 16'sh0000;
      end
    end else begin
      modOut    <= next_modOut;
      sincOut   <= next_sincOut;
      gainPipe  <= next_gainPipe;
      sampleOut <= next_sampleOut;
      for (int k = 0; k < SINC_TAPS; k++) begin
        tapLine[k] <= next_tap[k];
      end
    end
  end

endmodule

/* File: nqu_checker.sv */
// Port-level assertions for the upconverter
`timescale 1ns/100ps
module nqu_checker
  import nqu_pkg::*;
(
  input wire logic        clk,       // Sample clock
  input wire logic        reset,     // Async reset
  input wire logic        cfgWrite,  // Write strobe
  input wire logic [7:0]  cfgAddr,   // Write address
  input wire logic [31:0] cfgWdata,  // Write data
  input wire logic [7:0]  cfgRaddr,  // Readback address
  input wire logic [31:0] cfgRdata,  // Readback data
  input wire logic [15:0] sampleOut  // Output sample
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Bits whose readback the checker compares with the write; zero marks an unmapped address
  function automatic logic [31:0] keep(logic [7:0] a);
    case (a)
      ADDR_CTRL:              keep = 32'h0000_0002;
      ADDR_MODE:              keep = 32'h0000_0600;
      ADDR_STEP, ADDR_OFFSET: keep = 32'hffff_ffff;
      ADDR_PHASE:             keep = 32'h03ff_ffff;
      ADDR_GAIN:              keep = 32'h01ff_01ff;
      default:                keep = 32'h0;
    endcase
  endfunction
  chk_reset_out: assert property (
    disable iff (1'b0) reset |-> sampleOut == 16'h0)
    else $error("output not zero in reset");
  chk_reset_read: assert property (
    disable iff (1'b0) reset |-> cfgRdata == 32'h0)
    else $error("readback not zero in reset");
  chk_reset_values: assert property (
    $fell(reset) && !cfgWrite |=> cfgRdata == ($past(cfgRaddr) == ADDR_GAIN
      ? GAIN_RESET : $past(cfgRaddr) == ADDR_CTRL ? CTRL_RESET : 32'h0))
    else $error("register reset value wrong");
  chk_write_readback: assert property (
    cfgWrite && cfgAddr == cfgRaddr ##1 !cfgWrite && $stable(cfgRaddr)
    |=> ((cfgRdata ^ $past(cfgWdata, 2)) & keep($past(cfgRaddr))) == 0)
    else $error("written value not read back");
  chk_update_clears: assert property (
    cfgWrite && cfgAddr == ADDR_CTRL && cfgWdata[BIT_MAN_UPDATE]
    ##1 (!cfgWrite && cfgRaddr == ADDR_CTRL) [*2]
    |=> !cfgRdata[BIT_MAN_UPDATE])
    else $error("update bit did not clear");
  chk_read_stable: assert property (
    (!cfgWrite && $stable(cfgRaddr) && cfgRaddr != ADDR_CTRL) [*2]
    |=> $stable(cfgRdata))
    else $error("register changed without a write");
  chk_unmapped_zero: assert property (
    keep(cfgRaddr) == 32'h0 |=> cfgRdata == 32'h0)
    else $error("unmapped address reads nonzero");
endmodule
bind nqu_upconverter nqu_checker i_chk (.clk(clk), .reset(reset),
  .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata),
  .cfgRaddr(cfgRaddr), .cfgRdata(cfgRdata), .sampleOut(sampleOut));

/* File: nqu_host_model.sv */
// Configuration host and upstream sample source
`timescale 1ns/100ps
module nqu_host_model (
  input  wire logic        clk,       // Sample clock
  output logic             cfgWrite,  // Write strobe
  output logic      [7:0]  cfgAddr,   // Write address
  output logic      [31:0] cfgWdata,  // Write data
  output logic      [15:0] dataI,     // I sample
  output logic      [15:0] dataQ      // Q sample
);
  initial begin
    cfgWrite = 1'b0;
    cfgAddr = 8'h00;
    cfgWdata = 32'h0;
    dataI = 16'h0;
    dataQ = 16'h0;
  end
  // Strobe held across exactly one rising edge
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(negedge clk);
    cfgWrite = 1'b1;
    cfgAddr = a;
    cfgWdata = d;
    @(negedge clk);
    cfgWrite = 1'b0;
  endtask
  function automatic logic [31:0] gainWord(logic [8:0] g);
    return {7'h0, g, 7'h0, g};
  endfunction
  // host picks samples and offsets within range
  task automatic samp(logic [15:0] i, logic [15:0] q);
    @(negedge clk);
    dataI = i;
    dataQ = q;
  endtask
endmodule

/* File: nqu_upconverter_bench.sv */
// Self-checking bench for the upconverter
`timescale 1ns/100ps
module nqu_upconverter_bench
  import nqu_pkg::*;
;
  logic clk = 1'b0;
  logic reset, cfgWrite, pulseSync, txGateStrobe;
  logic [7:0] cfgAddr, cfgRaddr;
  logic [31:0] cfgWdata, cfgRdata, actOfs, regM [int];
  logic [15:0] dataI, dataQ, sampleOut, lfsr = 16'h0016;
  logic [7:0] addrs [7] = '{8'h00, 8'h01, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h05};
  logic [31:0] modes [4] = '{32'h200, 32'h400, 32'h600, 32'h0};
  bit autoX;
  int nFail, nCompared;
  always #5 clk = ~clk;
  nqu_host_model i_host (.clk(clk), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgWdata(cfgWdata), .dataI(dataI), .dataQ(dataQ));
  nqu_upconverter i_dut (.clk(clk), .reset(reset), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRaddr(cfgRaddr),
    .cfgRdata(cfgRdata), .pulseSync(pulseSync), .txGateStrobe(txGateStrobe),
    .dataI(dataI), .dataQ(dataQ), .sampleOut(sampleOut));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic check(logic [31:0] seen, logic [31:0] want);
    nCompared++;
    if (seen !== want) begin
      nFail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // Model: shadow copy per address, only the I offset reaches the output
  task automatic put(logic [7:0] a, logic [31:0] d);
    i_host.wr(a, d);
    if (a == ADDR_CTRL) begin
      autoX = d[BIT_AUTO_XFER];
      if (d[BIT_MAN_UPDATE])
        actOfs = regM[ADDR_OFFSET];
      d[BIT_MAN_UPDATE] = 1'b0;
    end
    regM[a] = d;
    if (autoX && a == ADDR_OFFSET)
      actOfs = d;
  endtask
  task automatic rd(logic [7:0] a);
    @(negedge clk) cfgRaddr = a;
    @(negedge clk) check(cfgRdata, regM.exists(a) ? regM[a] : 32'h0);
  endtask
  // Eight cycles covers the output latency while the inverse sinc is off
  task automatic outIs(logic [15:0] w);
    repeat (8) @(negedge clk);
    check({16'h0, sampleOut}, {16'h0, w});
  endtask
  // Quarter-turn carrier after a sync strobe, checked sample by sample
  task automatic carrier(logic [15:0] i, logic [15:0] q, bit inv);
    int c [4] = '{32767, 0, -32767, 0};
    int s;
    int v;
    i_host.samp(i, q);
    pulseSync = 1'b1;
    txGateStrobe = 1'b1;
    @(negedge clk);
    txGateStrobe = 1'b0;
    repeat (2) @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      s = inv ? c[(k + 3) % 4] : -c[(k + 3) % 4];
      v = ($signed(i) * c[k] + $signed(q) * s) >>> 15;
      check({16'h0, sampleOut}, {16'h0, v[15:0]});
      @(negedge clk);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, wrong %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    cfgRaddr = 8'h00;
    pulseSync = 1'b0;
    txGateStrobe = 1'b0;
    foreach (addrs[k]) if (k < 6) regM[addrs[k]] = 32'h0;
    regM[ADDR_CTRL] = CTRL_RESET;
    regM[ADDR_GAIN] = GAIN_RESET;
    autoX = 1'b1;
    actOfs = OFFSET_RESET;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    foreach (addrs[k]) rd(addrs[k]);
    $display("test done: reset values");
    for (int k = 0; k < 4; k++) begin
      put(ADDR_OFFSET, k == 0 ? 32'h8000_7fff : {rnd(), rnd()});
      rd(ADDR_OFFSET);
      outIs(actOfs[31:16]);
    end
    $display("test done: offsets");
    rd(ADDR_CTRL);
    put(ADDR_CTRL, 32'h0);
    put(ADDR_OFFSET, {rnd(), 16'h0});
    outIs(actOfs[31:16]);
    put(ADDR_CTRL, 32'h4);
    rd(ADDR_CTRL);
    outIs(actOfs[31:16]);
    put(ADDR_CTRL, 32'h2);
    $display("test done: buffered transfer");
    put(ADDR_GAIN, i_host.gainWord(9'h000));
    foreach (modes[k]) begin
      put(ADDR_MODE, modes[k]);
      rd(ADDR_MODE);
      repeat (12) i_host.samp(rnd(), rnd());
      check({16'h0, sampleOut}, {16'h0, actOfs[31:16]});
    end
    $display("test done: zero gain");
    put(ADDR_GAIN, i_host.gainWord(GAIN_UNITY));
    put(ADDR_OFFSET, 32'h7fff_0000);
    i_host.samp(16'h7fff, 16'h0);
    outIs(16'h7fff);
    put(ADDR_OFFSET, 32'h8000_0000);
    i_host.samp(16'h8000, 16'h0);
    outIs(16'h8000);
    $display("test done: saturation");
    put(ADDR_OFFSET, 32'h0);
    put(ADDR_STEP, 32'h4000_0000);
    carrier(16'h4000, 16'h0, 1'b0);
    carrier(16'h0, 16'h4000, 1'b0);
    put(ADDR_MODE, 32'h400);
    carrier(16'h0, 16'h4000, 1'b1);
    $display("test done: carrier phase");
    put(ADDR_STEP, {rnd(), rnd()});
    rd(ADDR_STEP);
    put(ADDR_PHASE, {rnd() & 16'h03ff, rnd()});
    rd(ADDR_PHASE);
    $display("test done: carrier settings");
    conclude();
  end
endmodule
